// ==== hdl/lfc_config.sv ====
`timescale 1ns/10ps
module lfc_config
  import lfc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [LFC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [LFC_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic slave_mode,
  input wire logic chk_done,
  input wire logic chk_match,
  output logic checksum_mode_sel,
  output logic [3:0] data_len,
  output logic len_reserved,
  output logic [5:0] frame_ident,
  output logic [8:0] baud_div,
  output logic [1:0] baud_prescale,
  output logic [4:0] baud_mult,
  output logic checksum_err_flag
);
  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] message_size_ctl;
  logic [7:0] baud_divider_low;
  logic [7:0] baud_multiplier_ctl;
  logic [7:0] frame_identifier;
  logic [7:0] error_flags_reg;
  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [3:0] aw_idx;
  logic [7:0] w_byte;
  logic w_lane0;
  logic do_write;
  logic [3:0] next_len;
  logic next_resv;
  logic err_clr;
  logic chk_fail;

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_idx <= 4'h0;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_idx <= s_axi_awaddr[LFC_ADDR_W-1:2];
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= LFC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      // unmapped index answers slverr, error register is read-only
      if (aw_idx inside {LFC_IDX_MSG_SIZE, LFC_IDX_DIV_LOW, LFC_IDX_MULT,
                         LFC_IDX_IDENT, LFC_IDX_ERR_CLR}) begin
        s_axi_bresp <= LFC_RESP_OKAY;
      end else begin
        s_axi_bresp <= LFC_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      message_size_ctl <= LFC_RESET_VAL;
      baud_divider_low <= LFC_RESET_VAL;
      baud_multiplier_ctl <= LFC_RESET_VAL;
      frame_identifier <= LFC_RESET_VAL;
    end else if (do_write && w_lane0) begin
      unique case (aw_idx)
        LFC_IDX_MSG_SIZE: message_size_ctl <= {w_byte[7], 3'h0, w_byte[3:0]};
        LFC_IDX_DIV_LOW: baud_divider_low <= w_byte;
        LFC_IDX_MULT: baud_multiplier_ctl <= w_byte;
        LFC_IDX_IDENT: frame_identifier <= {2'h0, w_byte[5:0]};
        default: ;
      endcase
    end
  end

  // set wins over the software clear
  assign err_clr = do_write && w_lane0 && aw_idx == LFC_IDX_ERR_CLR
                   && w_byte[LFC_ERR_CHK_BIT];
  assign chk_fail = chk_done && !chk_match;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_flags_reg <= LFC_RESET_VAL;
    end else if (chk_fail) begin
      error_flags_reg[LFC_ERR_CHK_BIT] <= 1'b1;
    end else if (err_clr) begin
      error_flags_reg[LFC_ERR_CHK_BIT] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  logic [3:0] ar_idx;
  logic [7:0] rd_byte;
  assign ar_idx = s_axi_araddr[LFC_ADDR_W-1:2];

  always_comb begin
    unique case (ar_idx)
      LFC_IDX_MSG_SIZE: rd_byte = message_size_ctl;
      LFC_IDX_DIV_LOW: rd_byte = baud_divider_low;
      LFC_IDX_MULT: rd_byte = baud_multiplier_ctl;
      LFC_IDX_IDENT: rd_byte = frame_identifier;
      LFC_IDX_ERR: rd_byte = error_flags_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  // read data is captured at the address edge, so a later write cannot tear it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= LFC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      if (ar_idx inside {LFC_IDX_MSG_SIZE, LFC_IDX_DIV_LOW, LFC_IDX_MULT,
                         LFC_IDX_IDENT, LFC_IDX_ERR}) begin
        s_axi_rresp <= LFC_RESP_OKAY;
      end else begin
        s_axi_rresp <= LFC_RESP_SLVERR;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // decoded outputs to the frame and bit-timing engine
  // ---------------------------------------------------------------
  lfc_len_decode lfc_len_decode_inst (
    .len_code(message_size_ctl[3:0]),
    .ident_hi(frame_identifier[5:4]),
    .data_len(next_len),
    .len_reserved(next_resv)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      checksum_mode_sel <= 1'b0;
      data_len <= 4'h0;
      len_reserved <= 1'b0;
      frame_ident <= 6'h00;
      baud_div <= 9'h000;
      baud_prescale <= 2'h0;
      baud_mult <= 5'h00;
      checksum_err_flag <= 1'b0;
    end else begin
      checksum_mode_sel <= message_size_ctl[LFC_CHK_MODE_BIT];
      data_len <= next_len;
      len_reserved <= next_resv;
      frame_ident <= frame_identifier[5:0];
      // range 200..511 is kept by software, not clamped here
      baud_div <= {baud_multiplier_ctl[LFC_DIV_MSB_BIT], baud_divider_low};
      baud_prescale <= baud_multiplier_ctl[7:6];
      // multiplier is masked in slave mode so it never shapes bit timing
      baud_mult <= slave_mode ? 5'h00 : baud_multiplier_ctl[5:1];
      checksum_err_flag <= error_flags_reg[LFC_ERR_CHK_BIT];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_CHK_MODE: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 checksum_mode_sel == $past(message_size_ctl[7]))
    else $error("checksum mode output does not follow register");
  AST_LEN_DIRECT: assert property (@(posedge aclk) disable iff (!aresetn)
    message_size_ctl[3:0] <= 4'h8 |=> data_len == $past(message_size_ctl[3:0]))
    else $error("direct length wrong");
  AST_LEN_ID: assert property (@(posedge aclk) disable iff (!aresetn)
    message_size_ctl[3:0] == 4'hf && frame_identifier[5:4] == 2'h3 |=> data_len == 4'h8)
    else $error("identifier length 8 wrong");
  AST_LEN_MAP: assert property (@(posedge aclk) disable iff (!aresetn)
    message_size_ctl[3:0] == 4'hf && !frame_identifier[5] |=> data_len == 4'h2)
    else $error("identifier length 2 wrong");
  AST_DIV: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 baud_div == {$past(baud_multiplier_ctl[0]), $past(baud_divider_low)})
    else $error("divider assembly wrong");
  AST_PRESCALE: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 baud_prescale == $past(baud_multiplier_ctl[7:6]))
    else $error("prescaler wrong");
  AST_MULT_SLAVE: assert property (@(posedge aclk) disable iff (!aresetn)
    slave_mode |=> baud_mult == 5'h00)
    else $error("multiplier active in slave mode");
  AST_SIZE_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    message_size_ctl[6:4] == 3'h0)
    else $error("size reserved bits nonzero");
  AST_ID_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_identifier[7:6] == 2'h0)
    else $error("identifier reserved bits nonzero");
  AST_RESET: assert property (@(posedge aclk)
    !aresetn |=> message_size_ctl == 8'h00 && baud_multiplier_ctl == 8'h00
    && baud_divider_low == 8'h00 && frame_identifier == 8'h00)
    else $error("registers not cleared by reset");
  AST_CHK_ERR: assert property (@(posedge aclk) disable iff (!aresetn)
    chk_done && !chk_match |=> ##1 checksum_err_flag)
    else $error("checksum error flag not raised");
  AST_WR_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid)
    else $error("write response missing");
  AST_LEN_RESV: assert property (@(posedge aclk) disable iff (!aresetn)
    message_size_ctl[3:0] > 4'h8 && message_size_ctl[3:0] != 4'hf |=> data_len == 4'h0)
    else $error("reserved length code not reported as zero");
  AST_LEN_FOUR: assert property (@(posedge aclk) disable iff (!aresetn)
    message_size_ctl[3:0] == 4'hf && frame_identifier[5:4] == 2'h2 |=> data_len == 4'h4)
    else $error("identifier length 4 wrong");
  AST_MULT_MASTER: assert property (@(posedge aclk) disable iff (!aresetn)
    !slave_mode |=> baud_mult == $past(baud_multiplier_ctl[5:1]))
    else $error("multiplier does not follow register in master mode");
  AST_IDENT_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 frame_ident == $past(frame_identifier[5:0]))
    else $error("identifier output does not follow register");
  AST_ERR_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
    err_clr && !chk_fail |=> !error_flags_reg[LFC_ERR_CHK_BIT])
    else $error("checksum error bit not cleared");
  AST_RD_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  AST_WR_REFUSE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");

  COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready);
  COV_READ: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready);
  COV_ID_LEN: cover property (@(posedge aclk) disable iff (!aresetn)
    message_size_ctl[3:0] == 4'hf);
  COV_CHK_ERR: cover property (@(posedge aclk) disable iff (!aresetn)
    chk_fail);
  COV_SLAVE_MASK: cover property (@(posedge aclk) disable iff (!aresetn)
    slave_mode && baud_multiplier_ctl[5:1] != 5'h00);
endmodule

// ==== hdl/lfc_pkg.sv ====
package lfc_pkg;
  // ---------------------------------------------------------------
  // register indices (printed offsets are not multiples of four)
  // ---------------------------------------------------------------
  localparam logic [3:0] LFC_IDX_MSG_SIZE = 4'hb;
  localparam logic [3:0] LFC_IDX_DIV_LOW = 4'hc;
  localparam logic [3:0] LFC_IDX_MULT = 4'hd;
  localparam logic [3:0] LFC_IDX_IDENT = 4'he;
  localparam logic [3:0] LFC_IDX_ERR = 4'ha;
  localparam logic [3:0] LFC_IDX_ERR_CLR = 4'hf;
  localparam int LFC_ADDR_W = 6;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int LFC_CHK_MODE_BIT = 7;
  localparam int LFC_DIV_MSB_BIT = 0;
  localparam int LFC_ERR_CHK_BIT = 1;
  localparam logic [7:0] LFC_RESET_VAL = 8'h00;
  localparam logic [3:0] LFC_LEN_MAX_CODE = 4'h8;
  localparam logic [3:0] LFC_LEN_FROM_ID = 4'hf;
  localparam logic [3:0] LFC_LEN_2 = 4'h2;
  localparam logic [3:0] LFC_LEN_4 = 4'h4;
  localparam logic [3:0] LFC_LEN_8 = 4'h8;
  localparam logic [8:0] LFC_DIV_MIN = 9'h0c8;
  localparam logic [1:0] LFC_RESP_OKAY = 2'h0;
  localparam logic [1:0] LFC_RESP_SLVERR = 2'h2;
endpackage

// ==== hdl/lfc_len_decode.sv ====
`timescale 1ns/10ps
// resolves the frame length code into a byte count
module lfc_len_decode
  import lfc_pkg::*;
(
  input wire logic [3:0] len_code,
  input wire logic [1:0] ident_hi,
  output logic [3:0] data_len,
  output logic len_reserved
);
  always_comb begin
    len_reserved = 1'b0;
    if (len_code == LFC_LEN_FROM_ID) begin
      unique case (ident_hi)
        2'h0, 2'h1: data_len = LFC_LEN_2;
        2'h2: data_len = LFC_LEN_4;
        2'h3: data_len = LFC_LEN_8;
      endcase
    end else if (len_code <= LFC_LEN_MAX_CODE) begin
      data_len = len_code;
    end else begin
      // reserved codes: report zero length and flag it
      data_len = 4'h0;
      len_reserved = 1'b1;
    end
  end
endmodule

// ==== verification/lfc_config_test.sv ====
`timescale 1ns/10ps
module lfc_config_test;
  import lfc_pkg::*;
  // ------------------------------------------------------------
  // signals and design instance
  // ------------------------------------------------------------
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [5:0] s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic slave_mode = 1'h0, chk_done = 1'h0, chk_match = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic checksum_mode_sel, len_reserved, checksum_err_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp, baud_prescale;
  logic [31:0] s_axi_rdata;
  logic [3:0] data_len;
  logic [5:0] frame_ident;
  logic [8:0] baud_div;
  logic [4:0] baud_mult;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;

  lfc_config lfc_config_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .slave_mode, .chk_done, .chk_match, .checksum_mode_sel, .data_len, .len_reserved,
    .frame_ident, .baud_div, .baud_prescale, .baud_mult, .checksum_err_flag
  );

  always #5 aclk = ~aclk;

  // the ceiling is far above the few hundred cycles the scenarios need
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // bus and compare helpers
  // ------------------------------------------------------------
  task automatic conclude();
    if (bad_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] i, input logic [7:0] d, input logic [1:0] r);
    logic a, w;
    // one edge between transfers so no strobe is assigned twice in a step
    @(posedge aclk);
    a = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // each channel is released only at the edge that takes it
    while (a | w) begin
      @(posedge aclk);
      if (a && s_axi_awready === 1'h1) begin
        a = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready === 1'h1) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (s_axi_bvalid !== 1'h1) @(posedge aclk);
    s_axi_bready <= 1'h0;
    cmp("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask

  task automatic rd(input logic [3:0] i, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    s_axi_rready <= 1'h0;
    cmp("rdata", e, s_axi_rdata);
    cmp("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask

  // decoded outputs trail the register by one clock
  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    for (int i = 11; i <= 14; i++) rd(4'(i), 32'h0, LFC_RESP_OKAY);
    cmp("outputs", 32'h0, {3'h0, checksum_mode_sel, data_len, len_reserved, frame_ident, baud_div,
        baud_prescale, baud_mult, checksum_err_flag});
  endtask

  task automatic t_size();
    logic [3:0] c;
    wr(LFC_IDX_MSG_SIZE, 8'hff, LFC_RESP_OKAY);
    rd(LFC_IDX_MSG_SIZE, 32'h8f, LFC_RESP_OKAY);
    settle();
    cmp("chk_mode", 32'h1, {31'h0, checksum_mode_sel});
    for (int k = 0; k < 15; k++) begin
      c = 4'(k);
      wr(LFC_IDX_MSG_SIZE, {4'h0, c}, LFC_RESP_OKAY);
      settle();
      cmp("data_len", (k <= 8) ? 32'(k) : 32'h0, {28'h0, data_len});
      cmp("len_reserved", {31'h0, k > 8}, {31'h0, len_reserved});
    end
    cmp("chk_mode", 32'h0, {31'h0, checksum_mode_sel});
  endtask

  task automatic t_ident();
    logic [3:0] tbl [4] = '{4'h2, 4'h2, 4'h4, 4'h8};
    wr(LFC_IDX_IDENT, 8'hff, LFC_RESP_OKAY);
    rd(LFC_IDX_IDENT, 32'h3f, LFC_RESP_OKAY);
    wr(LFC_IDX_MSG_SIZE, 8'h8f, LFC_RESP_OKAY);
    for (int h = 0; h < 4; h++) begin
      wr(LFC_IDX_IDENT, 8'(h * 16 + 5), LFC_RESP_OKAY);
      settle();
      cmp("data_len", {28'h0, tbl[h]}, {28'h0, data_len});
      cmp("frame_ident", 32'(h * 16 + 5), {26'h0, frame_ident});
    end
  endtask

  task automatic t_baud();
    wr(LFC_IDX_DIV_LOW, 8'hc8, LFC_RESP_OKAY);
    wr(LFC_IDX_MULT, 8'hff, LFC_RESP_OKAY);
    rd(LFC_IDX_DIV_LOW, 32'hc8, LFC_RESP_OKAY);
    rd(LFC_IDX_MULT, 32'hff, LFC_RESP_OKAY);
    settle();
    cmp("baud_div", 32'h1c8, {23'h0, baud_div});
    cmp("prescale", 32'h3, {30'h0, baud_prescale});
    cmp("mult", 32'h1f, {27'h0, baud_mult});
    @(posedge aclk);
    slave_mode <= 1'h1;
    settle();
    cmp("mult_slave", 32'h0, {27'h0, baud_mult});
    @(posedge aclk);
    slave_mode <= 1'h0;
    wr(LFC_IDX_DIV_LOW, 8'hff, LFC_RESP_OKAY);
    wr(LFC_IDX_MULT, 8'h40, LFC_RESP_OKAY);
    settle();
    cmp("baud_div", 32'h0ff, {23'h0, baud_div});
    cmp("prescale", 32'h1, {30'h0, baud_prescale});
  endtask

  task automatic pulse(input logic m);
    @(posedge aclk);
    chk_done <= 1'h1;
    chk_match <= m;
    @(posedge aclk);
    chk_done <= 1'h0;
    settle();
  endtask

  task automatic t_chk();
    pulse(1'h1);
    cmp("chk_err", 32'h0, {31'h0, checksum_err_flag});
    pulse(1'h0);
    cmp("chk_err", 32'h1, {31'h0, checksum_err_flag});
    rd(LFC_IDX_ERR, 32'h2, LFC_RESP_OKAY);
    wr(LFC_IDX_ERR, 8'h00, LFC_RESP_SLVERR);
    wr(LFC_IDX_ERR_CLR, 8'h02, LFC_RESP_OKAY);
    settle();
    cmp("chk_err", 32'h0, {31'h0, checksum_err_flag});
  endtask

  task automatic t_unmapped();
    rd(4'h0, 32'h0, LFC_RESP_SLVERR);
    wr(4'h1, 8'h55, LFC_RESP_SLVERR);
    s_axi_wstrb <= 4'h0;
    wr(LFC_IDX_DIV_LOW, 8'h11, LFC_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(LFC_IDX_DIV_LOW, 32'hff, LFC_RESP_OKAY);
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_size();
    t_ident();
    t_baud();
    t_chk();
    t_unmapped();
    conclude();
  end
endmodule
